/* cmtf_cfg.svh */
/*
 * Constants of the cycle-measure timer flag block: offsets, field
 * positions, reset values and codes.
 * Assumes inclusion by bare name from every file that needs a constant.
 */
// Function
// - eight-bit software read/write status register
// - bit 7 sets on counter FFFF to 0000
// - bit 7 clears by read-1 then write-0
// - bit 6 sets when capture exceeds limit in measurement mode
// - bit 6 clears by read-1 then write-0
// - bit 5 sets on counter equals limit
// - bit 5 never sets in measurement mode
// - bit 5 clears by read-1 then write-0
// - bit 4 picks external edge when 111
`ifndef CMTF_CFG_SVH
`define CMTF_CFG_SVH

// register byte offsets
`define CMTF_OFS_STATUS 8'h00
`define CMTF_OFS_MASK 8'h04
`define CMTF_OFS_CTRL 8'h08

// status and mask fields
`define CMTF_BIT_WRAP 7
`define CMTF_BIT_LIMIT 6
`define CMTF_BIT_MATCH 5
`define CMTF_BIT_EDGE 4
`define CMTF_FLAG_LSB 5

// control fields
`define CMTF_BIT_MODE 0
`define CMTF_CKS_LSB 1
`define CMTF_CKS_MSB 3

// values
`define CMTF_CNT_MAX 16'hFFFF
`define CMTF_CNT_ZERO 16'h0000
`define CMTF_CKS_EXT 3'h7
`define CMTF_RST_STATUS 8'h00
`define CMTF_RST_MASK 3'h0
`define CMTF_RST_CTRL 4'h0

`endif

/* cmtf_pkg.sv */
/*
 * Types of the cycle-measure timer flag block.
 * Assumes cmtf_cfg.svh for all numeric constants.
 */
`default_nettype none
package cmtf_pkg;

    // the three event flags, wrap first
    typedef struct packed {
        logic wrap;
        logic limit;
        logic match;
    } cmtf_flags_t;

    // counter operating mode
    typedef enum logic {
        CMTF_MODE_TIMER = 1'b0,
        CMTF_MODE_MEASURE = 1'b1
    } cmtf_mode_t;

    // bus slave phase, one-hot
    typedef enum logic [1:0] {
        CMTF_PH_IDLE = 2'b01,
        CMTF_PH_WDATA = 2'b10
    } cmtf_phase_t;

    // measurement inputs travel together
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] captured;
        logic [15:0] limit;
        logic capture_strobe;
    } cmtf_meas_t;

endpackage
`default_nettype wire

/* cmtf_top.sv */
/*
 * Flag and status logic of a 16-bit cycle-measurement timer, with an
 * AHB-Lite register slave and one level interrupt.
 * Assumes the counter, capture and limit inputs come from logic on clk;
 * the bus is a single AHB-Lite master issuing whole-word transfers.
 */
// Our own choices: the register offsets and the AHB-Lite slave port.
`include "cmtf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cmtf_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cmtf_pkg::cmtf_meas_t meas,
    output logic ext_count_edge_select,
    output logic ext_count_rising,
    output logic ext_count_falling,
    output logic cmtf_mode,
    output logic [2:0] clock_source_select,
    output logic irq
);

    // stored state
    cmtf_pkg::cmtf_flags_t flags;
    cmtf_pkg::cmtf_flags_t armed;
    cmtf_pkg::cmtf_flags_t flag_mask;
    cmtf_pkg::cmtf_phase_t phase;
    logic [7:0] wr_addr;
    logic [15:0] count_q;
    logic match_q;

    // address phase decode
    wire logic addr_valid = hsel && htrans[1] && hready;
    wire logic rd_take = addr_valid && !hwrite;
    wire logic wr_take = addr_valid && hwrite;
    wire logic [7:0] a_ofs = haddr[7:0];
    wire logic a_status = (a_ofs == `CMTF_OFS_STATUS);
    wire logic a_mask = (a_ofs == `CMTF_OFS_MASK);
    wire logic a_ctrl = (a_ofs == `CMTF_OFS_CTRL);
    wire logic rd_status = rd_take && a_status;

    // data phase write decode; hwdata only valid now
    wire logic in_wdata = (phase == cmtf_pkg::CMTF_PH_WDATA);
    wire logic wr_status = in_wdata && (wr_addr == `CMTF_OFS_STATUS);
    wire logic wr_mask = in_wdata && (wr_addr == `CMTF_OFS_MASK);
    wire logic wr_ctrl = in_wdata && (wr_addr == `CMTF_OFS_CTRL);
    wire logic [2:0] wr_flag_bits = hwdata[`CMTF_BIT_WRAP:`CMTF_FLAG_LSB];

    // status byte as software sees it; low nibble reserved, reads zero
    wire logic [7:0] status_view = {flags, ext_count_edge_select, 4'h0};
    wire logic [7:0] mask_view = {flag_mask, 5'h00};
    wire logic [7:0] ctrl_view = {4'h0, clock_source_select, cmtf_mode};

    // read mux; unmapped offsets read zero with an OKAY answer
    wire logic [7:0] rd_byte = a_status ? status_view :
                               a_mask ? mask_view :
                               a_ctrl ? ctrl_view : 8'h00;

    // event detection
    wire logic in_measure = (cmtf_mode == cmtf_pkg::CMTF_MODE_MEASURE);
    // wrap seen as a step from all ones to zero, not as any reload
    wire logic wrap_evt = (count_q == `CMTF_CNT_MAX)
                          && (meas.count == `CMTF_CNT_ZERO);
    wire logic limit_evt = in_measure && meas.capture_strobe
                           && (meas.captured > meas.limit);
    wire logic match_now = (meas.count == meas.limit);
    // only the first cycle of equality counts, and never while measuring
    wire logic match_evt = match_now && !match_q && !in_measure;
    wire cmtf_pkg::cmtf_flags_t set_evt = '{wrap: wrap_evt,
                                            limit: limit_evt,
                                            match: match_evt};
    wire logic [2:0] set_vec = set_evt;
    wire logic [2:0] flag_vec = flags;
    wire logic [2:0] armed_vec = armed;

    // per-flag next state: set wins, clear needs a prior read of one
    logic [2:0] next_flag;
    logic [2:0] next_armed;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            wire logic clr = wr_status && armed_vec[gi]
                             && !wr_flag_bits[gi];
            // writing a one never touches the flag
            assign next_flag[gi] = set_vec[gi]
                                   || (flag_vec[gi] && !clr);
            // arm on a read that returned one; a status write disarms unless a status read is taken in the same cycle
            assign next_armed[gi] = rd_status ? flag_vec[gi] :
                                    wr_status ? 1'b0 : armed_vec[gi];
        end
    endgenerate

    // flag registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= '0;
            armed <= '0;
        end else begin
            flags <= next_flag;
            armed <= next_armed;
        end
    end

    // edge select bit, plain read/write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_count_edge_select <= 1'b0;
        end else if (wr_status) begin
            ext_count_edge_select <= hwdata[`CMTF_BIT_EDGE];
        end
    end

    // edge steering only applies with the external clock source
    wire logic ext_src = (clock_source_select == `CMTF_CKS_EXT);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_count_rising <= 1'b0;
            ext_count_falling <= 1'b0;
        end else begin
            ext_count_rising <= ext_src && ext_count_edge_select;
            ext_count_falling <= ext_src && !ext_count_edge_select;
        end
    end

    // mask and control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_mask <= `CMTF_RST_MASK;
            {clock_source_select, cmtf_mode} <= `CMTF_RST_CTRL;
        end else begin
            if (wr_mask) begin
                flag_mask <= hwdata[`CMTF_BIT_WRAP:`CMTF_FLAG_LSB];
            end
            if (wr_ctrl) begin
                cmtf_mode <= hwdata[`CMTF_BIT_MODE];
                clock_source_select <= hwdata[`CMTF_CKS_MSB:`CMTF_CKS_LSB];
            end
        end
    end

    // history for wrap and match edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= `CMTF_CNT_ZERO;
            match_q <= 1'b0;
        end else begin
            count_q <= meas.count;
            match_q <= match_now;
        end
    end

    // interrupt level, registered so the output comes from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flag & flag_mask);
        end
    end

    // bus phase tracking; zero wait states, so no stall is ever needed
    cmtf_pkg::cmtf_phase_t next_phase;
    assign next_phase = wr_take ? cmtf_pkg::CMTF_PH_WDATA
                                : cmtf_pkg::CMTF_PH_IDLE;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase <= cmtf_pkg::CMTF_PH_IDLE;
            wr_addr <= 8'h00;
        end else begin
            case (phase)
                cmtf_pkg::CMTF_PH_IDLE: begin
                    phase <= next_phase;
                end
                cmtf_pkg::CMTF_PH_WDATA: begin
                    phase <= next_phase;
                end
                default: begin
                    phase <= cmtf_pkg::CMTF_PH_IDLE;
                end
            endcase
            if (wr_take) begin
                wr_addr <= a_ofs;
            end
        end
    end

    // read data is captured at the address edge and stands one cycle;
    // a read right behind a write to the same word sees the old value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_wrap_step;
        (count_q == `CMTF_CNT_MAX) && (meas.count == `CMTF_CNT_ZERO);
    endsequence

    sequence s_read_one_wrap;
        rd_status && flags.wrap;
    endsequence

    // the read-then-write pair may be any distance apart, so the arm bit links the steps
    sequence s_clear_write_wrap;
        wr_status && armed.wrap && !hwdata[`CMTF_BIT_WRAP] && !wrap_evt;
    endsequence

    a_wrap_sets: assert property (
        s_wrap_step |=> flags.wrap
    ) else $error("wrap flag not set after counter wrap");

    a_wrap_arms: assert property (
        s_read_one_wrap |=> armed.wrap
    ) else $error("wrap flag not armed by a read of one");

    a_wrap_read_clear: assert property (
        s_clear_write_wrap |=> !flags.wrap
    ) else $error("wrap flag not cleared by read then write zero");

    sequence s_read_one_limit;
        rd_status && flags.limit;
    endsequence

    sequence s_clear_write_limit;
        wr_status && armed.limit && !hwdata[`CMTF_BIT_LIMIT] && !limit_evt;
    endsequence

    a_limit_arms: assert property (
        s_read_one_limit |=> armed.limit
    ) else $error("limit flag not armed by a read of one");

    a_limit_read_clear: assert property (
        s_clear_write_limit |=> !flags.limit
    ) else $error("limit flag not cleared by read then write zero");

    sequence s_read_one_match;
        rd_status && flags.match;
    endsequence

    sequence s_clear_write_match;
        wr_status && armed.match && !hwdata[`CMTF_BIT_MATCH] && !match_evt;
    endsequence

    a_match_arms: assert property (
        s_read_one_match |=> armed.match
    ) else $error("match flag not armed by a read of one");

    a_match_read_clear: assert property (
        s_clear_write_match |=> !flags.match
    ) else $error("match flag not cleared by read then write zero");

    a_match_once: assert property (
        match_now && match_q && !flags.match |=> !flags.match
    ) else $error("match flag set again by a stalled equal count");

    a_unarmed_keeps: assert property (
        wr_status && (armed == '0) |=> (flags & $past(flags)) == $past(flags)
    ) else $error("flag cleared by a write without a prior read");

    a_clear_needs_arm: assert property (
        (flags != '0) && ((flags & ~next_flag) != '0)
        |-> wr_status && ((armed & ~next_flag & flags) == (flags & ~next_flag))
    ) else $error("flag cleared without prior read of one");

    a_limit_sets: assert property (
        in_measure && meas.capture_strobe && (meas.captured > meas.limit)
        |=> flags.limit
    ) else $error("limit flag not set on capture above limit");

    a_limit_holds: assert property (
        flags.limit && !wr_status |=> flags.limit
    ) else $error("limit flag dropped without a write");

    a_match_sets: assert property (
        !in_measure && match_now && !match_q |=> flags.match
    ) else $error("match flag not set in timer mode");

    a_match_measure: assert property (
        !flags.match && in_measure && !wr_ctrl |=> !flags.match
    ) else $error("match flag set in measurement mode");

    a_write_one: assert property (
        wr_status && (wr_flag_bits == 3'h7) && (flags != '0)
        |=> (flags & $past(flags)) == $past(flags)
    ) else $error("writing one changed a flag");

    a_set_wins: assert property (
        (set_vec != 3'h0) |=> ((flags & $past(set_vec)) == $past(set_vec))
    ) else $error("set event lost against a clear");

    a_edge_route: assert property (
        ext_src && !wr_status
        |=> ext_count_rising == ext_count_edge_select
            && ext_count_falling == !ext_count_edge_select
    ) else $error("external edge select not routed");

    a_edge_rw: assert property (
        wr_status |=> ext_count_edge_select == $past(hwdata[`CMTF_BIT_EDGE])
    ) else $error("edge select bit not written");

    a_status_read: assert property (
        rd_status |=> hrdata[7:0] == $past(status_view) && hrdata[31:8] == 24'h0
    ) else $error("status read data wrong");

    // irq is built from next flags and the mask as it stood one cycle back
    a_irq_level: assert property (
        irq == |(flags & $past(flag_mask))
    ) else $error("interrupt level does not follow masked flags");

    a_bus_okay: assert property (
        hreadyout && !hresp
    ) else $error("slave stalled or answered error");

    // reset itself must be watched, so the default disable is overridden here
    a_reset_zero: assert property (
        disable iff (1'b0)
        sys_rst |=> (flags == '0) && !ext_count_edge_select && !irq
    ) else $error("flag or edge bit not zero after reset");

    a_mask_write: assert property (
        wr_mask |=> flag_mask == $past(hwdata[`CMTF_BIT_WRAP:`CMTF_FLAG_LSB])
    ) else $error("mask register not written");

    a_ctrl_write: assert property (
        wr_ctrl
        |=> {clock_source_select, cmtf_mode} == $past(hwdata[`CMTF_CKS_MSB:`CMTF_BIT_MODE])
    ) else $error("control register not written");

    a_idle_rdata: assert property (
        !rd_take |=> hrdata == 32'h0000_0000
    ) else $error("read data not zero outside a read data phase");

endmodule
`default_nettype wire

/* test_cycle_measure_timer_flags.sv */
/*
 * Self-checking bench of the cycle-measure timer flag block: bus tasks,
 * event stimulus on the measurement inputs, flag clearing and interrupt.
 * Assumes one AHB-Lite slave whose hreadyout loops back as hready.
 */
`include "cmtf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module test_cycle_measure_timer_flags;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, edge_sel, ext_rise, ext_fall, mode_out, irq;
    wire logic [2:0] cks_out;
    cmtf_pkg::cmtf_meas_t meas = '{16'h0001, 16'h0000, 16'h8000, 1'b0};
    int err_total = 0;
    int checked = 0;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    cmtf_top u_cmtf_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas),
        .ext_count_edge_select(edge_sel), .ext_count_rising(ext_rise),
        .ext_count_falling(ext_fall), .cmtf_mode(mode_out),
        .clock_source_select(cks_out), .irq(irq));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // counter steps all ones to zero; the wrap is seen at the second edge
    task automatic wrap_pulse;
        meas.count <= 16'hFFFF;
        tick(1);
        meas.count <= 16'h0000;
        tick(1);
        meas.count <= 16'h0001;
        tick(1);
    endtask

    // one whole-word transfer; hready and read data taken at the rising edge, no fixed latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do begin
            @(posedge clk);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask

    // without a prior read of 1 a zero write must not clear; write 1 keeps the flag
    task automatic clr_seq(input logic [7:0] m);
        wr(`CMTF_OFS_STATUS, 32'h00000000);
        rd_chk(`CMTF_OFS_STATUS, {24'h0, m});
        wr(`CMTF_OFS_STATUS, {24'h0, m});
        rd_chk(`CMTF_OFS_STATUS, {24'h0, m});
        chk({31'h0, irq}, 32'h1);
        wr(`CMTF_OFS_STATUS, 32'h00000000);
        rd_chk(`CMTF_OFS_STATUS, 32'h00000000);
        tick(1);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog, far beyond the hundred-odd cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done;
    end

    initial begin
        tick(8);
        sys_rst <= 1'b0;
        rd_chk(`CMTF_OFS_STATUS, 32'h00000000);
        rd_chk(`CMTF_OFS_MASK, 32'h00000000);
        rd_chk(`CMTF_OFS_CTRL, 32'h00000000);
        chk({30'h0, edge_sel, irq}, 32'h0);
        wr(8'h0C, 32'h000000FF);
        rd_chk(8'h0C, 32'h00000000);
        $display("test reset_and_map done");

        // edge select only matters with external clock source
        wr(`CMTF_OFS_CTRL, 32'h0000000E);
        rd_chk(`CMTF_OFS_CTRL, 32'h0000000E);
        wr(`CMTF_OFS_STATUS, 32'h00000010);
        rd_chk(`CMTF_OFS_STATUS, 32'h00000010);
        tick(2);
        chk({27'h0, cks_out, ext_rise, ext_fall}, {27'h0, 3'h7, 2'b10});
        wr(`CMTF_OFS_STATUS, 32'h00000000);
        tick(2);
        chk({29'h0, edge_sel, ext_rise, ext_fall}, 32'h1);
        wr(`CMTF_OFS_CTRL, 32'h00000000);
        $display("test edge_select done");

        // wrap with mask off: flag but no interrupt
        wrap_pulse();
        tick(1);
        chk({31'h0, irq}, 32'h0);
        wr(`CMTF_OFS_MASK, 32'h000000E0);
        tick(2);
        clr_seq(8'h80);
        // a clear whose data phase meets a fresh wrap must leave the flag set
        wrap_pulse();
        rd_chk(`CMTF_OFS_STATUS, 32'h00000080);
        fork
            wr(`CMTF_OFS_STATUS, 32'h00000000);
            wrap_pulse();
        join
        rd_chk(`CMTF_OFS_STATUS, 32'h00000080);
        chk({31'h0, irq}, 32'h1);
        wr(`CMTF_OFS_STATUS, 32'h00000000);
        rd_chk(`CMTF_OFS_STATUS, 32'h00000000);
        $display("test wrap done");

        meas.limit <= 16'h1234;
        meas.count <= 16'h1234;
        tick(1);
        meas.count <= 16'h1235;
        tick(2);
        clr_seq(8'h20);
        $display("test match done");

        // measurement mode: equal count must not set match; capture above limit sets
        wr(`CMTF_OFS_CTRL, 32'h00000001);
        tick(1);
        chk({31'h0, mode_out}, 32'h1);
        meas.count <= 16'h1234;
        meas.captured <= 16'h1234;
        meas.capture_strobe <= 1'b1;
        tick(1);
        meas.capture_strobe <= 1'b0;
        meas.count <= 16'h0001;
        tick(2);
        rd_chk(`CMTF_OFS_STATUS, 32'h00000000);
        meas.captured <= 16'h1235;
        meas.capture_strobe <= 1'b1;
        tick(1);
        meas.capture_strobe <= 1'b0;
        tick(2);
        clr_seq(8'h40);
        $display("test limit done");
        test_done;
    end
endmodule
`default_nettype wire
